// ==== hw/srm_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the result/monitor register slice
// Assumes: 7-bit register address, 16-bit register words, 50 MHz clock
// Notes: fields of the monitor word are bit positions within the 16-bit word
`ifndef SRM_MAP_SVH
`define SRM_MAP_SVH

`define SRM_OFS_STEP12 7'h1c
`define SRM_OFS_STEP13 7'h1d
`define SRM_OFS_STEP14 7'h1e
`define SRM_OFS_STEP15 7'h1f
`define SRM_OFS_MONCFG 7'h40
`define SRM_OFS_SEC1_LO 7'h40
`define SRM_OFS_SEC1_HI 7'h59

`define SRM_RESULT_RESET 16'h0000
`define SRM_MONCFG_RESET 16'h0000
// writable bits: 15,14,13,12,8,2,1,0
`define SRM_MONCFG_WMASK 16'hf107

`define SRM_BIT_MAP_CHECK_EN 15
`define SRM_BIT_CRC_ANSI 14
`define SRM_BIT_SCLK_CNT_EN 13
`define SRM_BIT_TIMEOUT_EN 12
`define SRM_BIT_FAULT_POLARITY 8
`define SRM_BIT_ABSENT_POL 2
`define SRM_LSB_ABSENT_WIN 0

`define SRM_POLY_CCITT 16'h1021
`define SRM_POLY_ANSI 16'h8005
`define SRM_CRC_SEED 16'hffff

// oscillator-cycle counts, taken as clock cycles here
`define SRM_TIMEOUT_CYCLES 32'd16384
`define SRM_ABSENT_WIN1 32'd5120
`define SRM_ABSENT_WIN2 32'd10240
`define SRM_ABSENT_WIN3 32'd20480

`endif

// ==== hw/srm_pkg.sv ====
// Purpose: types shared by the register slice
// Assumes: nothing beyond the map header
// Notes: states are one-hot
package srm_pkg;
  typedef enum logic [2:0] {
    SRM_IDLE = 3'b001,
    SRM_BUSY = 3'b010,
    SRM_DONE = 3'b100
  } srm_crc_state_t;
  typedef enum logic [1:0] {
    SRM_WIN_OFF = 2'b00,
    SRM_WIN_1 = 2'b01,
    SRM_WIN_2 = 2'b10,
    SRM_WIN_3 = 2'b11
  } srm_window_t;
endpackage

// ==== hw/srm_crc_step.sv ====
// Purpose: one 16-bit word folded into a 16-bit crc, msb first
// Assumes: polynomial given without its top term
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module srm_crc_step (
  input wire logic [15:0] crc_in,
  input wire logic [15:0] word,
  input wire logic [15:0] poly,
  output logic [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ word[i]) begin
        c = {c[14:0], 1'b0} ^ poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule // srm_crc_step

// ==== hw/srm_regs.sv ====
// Purpose: step 12..15 result registers and the integrity monitor configuration word
// Assumes: frame decoder delivers decoded accesses and crc-valid command pulses on this clock;
//   chip_select_n arrives from a pin
// Notes: map crc walks section 1 one word per cycle, words outside this slice count as zero
//
// How it works
// RQ1 - four read-only results, steps twelve to fifteen
// RQ2 - results are signed two's complement words
// RQ3 - steps 13-15 at 1Dh upward, reset zero
// RQ4 - monitor word at 40h, resets to zero
// RQ5 - bit 15 enables section 1 map crc
// RQ6 - bit 14 picks CCITT or ANSI polynomial
// RQ7 - reserved bits ignore writes, read zero
// RQ8 - serial timeout drops rest of frame
// RQ9 - absent host flagged after chosen window
// RQ10 - CCITT 1021h, ANSI 8005h, msb first
`timescale 1ns/1ps
`include "srm_map.svh"
module srm_regs
  import srm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic result_we,
  input wire logic [1:0] result_step,
  input wire logic signed [15:0] result_data,
  input wire logic chip_select_n,
  input wire logic cmd_crc_ok,
  output logic frame_drop,
  output logic crc_ansi_sel,
  output logic [15:0] map_crc,
  output logic map_crc_valid,
  output logic absent_host,
  output logic absent_host_pin,
  output logic fault_output_polarity,
  output logic sclk_count_enable
);
  logic signed [15:0] step_result [0:3];
  logic [15:0] moncfg;
  logic [15:0] poly;
  logic [15:0] next_crc;
  logic [15:0] crc_word;
  logic [6:0] walk_addr;
  logic [15:0] crc_acc;
  srm_crc_state_t crc_state;
  logic cs_meta, cs_sync, cs_prev;
  logic [14:0] to_count;
  logic [14:0] absent_count;
  logic [14:0] absent_limit;

  // RQ1 result capture
  // RQ2 stored as signed words
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // RQ3 zero after reset
      for (int i = 0; i < 4; i++) begin
        step_result[i] <= `SRM_RESULT_RESET;
      end
    end else if (result_we) begin
      step_result[result_step] <= result_data;
    end
  end

  // RQ4 monitor word reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      moncfg <= `SRM_MONCFG_RESET;
    end else if (reg_wr && reg_addr == `SRM_OFS_MONCFG) begin
      // RQ7 reserved bits masked
      moncfg <= reg_wdata & `SRM_MONCFG_WMASK;
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd) begin
        reg_rdata <= reg_rdata;
      // RQ3 consecutive result offsets
      end else if (reg_addr == `SRM_OFS_STEP12) begin
        reg_rdata <= step_result[0];
      end else if (reg_addr == `SRM_OFS_STEP13) begin
        reg_rdata <= step_result[1];
      end else if (reg_addr == `SRM_OFS_STEP14) begin
        reg_rdata <= step_result[2];
      end else if (reg_addr == `SRM_OFS_STEP15) begin
        reg_rdata <= step_result[3];
      end else if (reg_addr == `SRM_OFS_MONCFG) begin
        reg_rdata <= moncfg;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // plain configuration outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_ansi_sel <= 1'b0;
      fault_output_polarity <= 1'b0;
      sclk_count_enable <= 1'b0;
    end else begin
      // RQ6 shared polynomial select
      crc_ansi_sel <= moncfg[`SRM_BIT_CRC_ANSI];
      fault_output_polarity <= moncfg[`SRM_BIT_FAULT_POLARITY];
      sclk_count_enable <= moncfg[`SRM_BIT_SCLK_CNT_EN];
    end
  end

  // RQ10 generator choice
  assign poly = moncfg[`SRM_BIT_CRC_ANSI] ? `SRM_POLY_ANSI : `SRM_POLY_CCITT;
  assign crc_word = (walk_addr == `SRM_OFS_MONCFG) ? moncfg : 16'h0000;

  srm_crc_step u_crc_step (
    .crc_in(crc_acc),
    .word(crc_word),
    .poly(poly),
    .crc_out(next_crc)
  );

  // RQ5 section 1 walk, restarts continuously while enabled
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_state <= SRM_IDLE;
      walk_addr <= `SRM_OFS_SEC1_LO;
      crc_acc <= `SRM_CRC_SEED;
      map_crc <= 16'h0000;
      map_crc_valid <= 1'b0;
    end else if (!moncfg[`SRM_BIT_MAP_CHECK_EN]) begin
      crc_state <= SRM_IDLE;
      walk_addr <= `SRM_OFS_SEC1_LO;
      crc_acc <= `SRM_CRC_SEED;
      map_crc_valid <= 1'b0;
    end else begin
      case (crc_state)
        SRM_IDLE: begin
          walk_addr <= `SRM_OFS_SEC1_LO;
          crc_acc <= `SRM_CRC_SEED;
          crc_state <= SRM_BUSY;
        end
        SRM_BUSY: begin
          crc_acc <= next_crc;
          walk_addr <= walk_addr + 7'h01;
          if (walk_addr == `SRM_OFS_SEC1_HI) begin
            crc_state <= SRM_DONE;
          end
        end
        SRM_DONE: begin
          map_crc <= crc_acc;
          map_crc_valid <= 1'b1;
          crc_state <= SRM_IDLE;
        end
        default: begin
          crc_state <= SRM_IDLE;
        end
      endcase
    end
  end

  // two-stage sync of the chip select pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= chip_select_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // RQ8 frame timeout; drop holds until next falling edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      to_count <= 15'h0000;
      frame_drop <= 1'b0;
    end else if (cs_prev && !cs_sync) begin
      to_count <= 15'h0000;
      frame_drop <= 1'b0;
    end else if (!cs_sync && moncfg[`SRM_BIT_TIMEOUT_EN] && !frame_drop) begin
      to_count <= to_count + 15'h0001;
      if (to_count == 15'(`SRM_TIMEOUT_CYCLES - 1)) begin
        frame_drop <= 1'b1;
      end
    end
  end

  always_comb begin
    case (srm_window_t'(moncfg[`SRM_LSB_ABSENT_WIN +: 2]))
      SRM_WIN_1: absent_limit = 15'(`SRM_ABSENT_WIN1);
      SRM_WIN_2: absent_limit = 15'(`SRM_ABSENT_WIN2);
      SRM_WIN_3: absent_limit = 15'(`SRM_ABSENT_WIN3);
      default: absent_limit = 15'h0000;
    endcase
  end

  // RQ9 absent-host watchdog; cleared only by disabling the window
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      absent_count <= 15'h0000;
      absent_host <= 1'b0;
    end else if (absent_limit == 15'h0000) begin
      absent_count <= 15'h0000;
      absent_host <= 1'b0;
    end else if (cmd_crc_ok) begin
      absent_count <= 15'h0000;
    end else if (!absent_host) begin
      absent_count <= absent_count + 15'h0001;
      if (absent_count >= absent_limit - 15'h0001) begin
        absent_host <= 1'b1;
      end
    end
  end

  // pin level follows the polarity bit; active low by default
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      absent_host_pin <= 1'b1;
    end else begin
      absent_host_pin <= absent_host ~^ moncfg[`SRM_BIT_ABSENT_POL];
    end
  end
endmodule // srm_regs

// ==== tb/srm_regs_asserts.sv ====
// Purpose: port checks of the result and monitor register slice
// Assumes: one clock, async active-low reset
// Notes: latencies as the design registers them
`timescale 1ns/1ps
module srm_regs_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic chip_select_n,
  input wire logic frame_drop,
  input wire logic crc_ansi_sel,
  input wire logic map_crc_valid,
  input wire logic absent_host
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic cfg_wr = reg_wr && reg_addr == 7'h40;
  property p_ack; reg_rd |=> reg_rvalid; endproperty
  a_ack: assert property (p_ack) else $error("read unanswered");
  property p_rsvd; reg_rvalid && $past(reg_addr) == 7'h40 |-> (reg_rdata & 16'h0ef8) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_poly; cfg_wr |-> ##2 crc_ansi_sel == $past(reg_wdata[14], 2); endproperty
  a_poly: assert property (p_poly) else $error("polynomial select wrong");
  property p_map_on; cfg_wr && reg_wdata[15] |-> ##[1:64] map_crc_valid; endproperty
  a_map_on: assert property (p_map_on) else $error("map check never done");
  property p_map_off; cfg_wr && !reg_wdata[15] |-> ##2 !map_crc_valid; endproperty
  a_map_off: assert property (p_map_off) else $error("map check while off");
  property p_drop; $rose(frame_drop) |-> !chip_select_n && !$past(chip_select_n, 8); endproperty
  a_drop: assert property (p_drop) else $error("drop without low select");
  property p_drop_clr; $fell(chip_select_n) |-> ##[1:8] !frame_drop; endproperty
  a_drop_clr: assert property (p_drop_clr) else $error("drop not cleared");
  property p_hold; absent_host && !cfg_wr && !$past(cfg_wr) && !$past(cfg_wr, 2) |=> absent_host; endproperty
  a_hold: assert property (p_hold) else $error("absent flag lost");
endmodule // srm_regs_asserts
bind srm_regs srm_regs_asserts i_chk (
  .clock(clock),
  .rstn(rstn),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .chip_select_n(chip_select_n),
  .frame_drop(frame_drop),
  .crc_ansi_sel(crc_ansi_sel),
  .map_crc_valid(map_crc_valid),
  .absent_host(absent_host)
);

// ==== tb/srm_host.sv ====
// Purpose: host model making register accesses and valid commands
// Assumes: one access at a time
// Notes: released write data shows its inverse
`timescale 1ns/1ps
module srm_host (
  input wire logic clock,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [6:0] reg_addr = 7'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic cmd_crc_ok = 1'b0
);
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    // answer stands between the two edges; take it at the closing edge, before it is replaced
    @(posedge clock);
    d = reg_rvalid ? reg_rdata : 16'hxxxx;
  endtask
  task automatic ping;
    @(posedge clock);
    cmd_crc_ok <= 1'b1;
    @(posedge clock);
    cmd_crc_ok <= 1'b0;
  endtask
endmodule // srm_host

// ==== tb/srm_regs_bench.sv ====
// Purpose: self-checking bench of the register slice
// Assumes: host model drives the register strobes
// Notes: timeout and watchdog run their full counts
`timescale 1ns/1ps
module srm_regs_bench;
  typedef struct {logic [6:0] a; logic [15:0] d; logic [15:0] e;} srm_row_t;
  srm_row_t rows [7] = '{'{7'h1c, 16'hffff, 16'h8000}, '{7'h1d, 16'h1234, 16'h7fff}, '{7'h1e, 16'h0000, 16'hffff},
    '{7'h1f, 16'haaaa, 16'h0001}, '{7'h40, 16'h7fff, 16'h7107}, '{7'h40, 16'h0ef8, 16'h0000}, '{7'h30, 16'hffff, 16'h0000}};
  logic clock, rstn, reg_wr, reg_rd, reg_rvalid, result_we, chip_select_n, cmd_crc_ok, frame_drop, crc_ansi_sel;
  logic map_crc_valid, absent_host, absent_host_pin, fault_output_polarity, sclk_count_enable;
  logic [6:0] reg_addr;
  logic [1:0] result_step;
  logic [15:0] reg_wdata, reg_rdata, result_data, map_crc, got, w;
  int n_errors = 0;
  int n_checks = 0;
  srm_regs i_dut (
    .clock(clock),
    .rstn(rstn),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .result_we(result_we),
    .result_step(result_step),
    .result_data(result_data),
    .chip_select_n(chip_select_n),
    .cmd_crc_ok(cmd_crc_ok),
    .frame_drop(frame_drop),
    .crc_ansi_sel(crc_ansi_sel),
    .map_crc(map_crc),
    .map_crc_valid(map_crc_valid),
    .absent_host(absent_host),
    .absent_host_pin(absent_host_pin),
    .fault_output_polarity(fault_output_polarity),
    .sclk_count_enable(sclk_count_enable)
  );
  srm_host i_host (
    .clock(clock),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .cmd_crc_ok(cmd_crc_ok)
  );
  // 26 words of section 1, only the first one nonzero
  function automatic logic [15:0] crc_of(input logic [15:0] v, input logic [15:0] p);
    logic [15:0] c = 16'hffff;
    for (int k = 0; k < 416; k++) c = (c[15] ^ (k < 16 && v[15 - k])) ? (c << 1) ^ p : c << 1;
    return c;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    // about 36k cycles of tests, twice that before giving up
    #1500000;
    n_errors++;
    stop_test;
  end
  initial begin
    rstn = 1'b0;
    result_we = 1'b0;
    result_step = 2'h0;
    result_data = 16'h0000;
    chip_select_n = 1'b1;
    tick(5);
    chk(absent_host_pin, 1'b1);
    @(posedge clock) rstn <= 1'b1;
    foreach (rows[i]) begin
      i_host.rd(rows[i].a, got);
      chk(got, 16'h0000);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      i_host.wr(rows[i].a, rows[i].d);
      if (rows[i].a[6:2] == 5'h07) begin
        @(posedge clock);
        result_we <= 1'b1;
        result_step <= rows[i].a[1:0];
        result_data <= rows[i].e;
        @(posedge clock);
        result_we <= 1'b0;
        result_data <= ~rows[i].e;
      end
      i_host.rd(rows[i].a, got);
      chk(got, rows[i].e);
    end
    $display("table test done");
    for (int p = 0; p < 2; p++) begin
      w = p ? 16'hc000 : 16'h8000;
      i_host.wr(7'h40, w);
      tick(70);
      chk({map_crc_valid, crc_ansi_sel}, {1'b1, p[0]});
      chk(map_crc, crc_of(w, p ? 16'h8005 : 16'h1021));
    end
    i_host.wr(7'h40, 16'h3100);
    tick(3);
    chk({map_crc_valid, sclk_count_enable, fault_output_polarity}, 3'b011);
    $display("map test done");
    @(posedge clock) chip_select_n <= 1'b0;
    tick(16384);
    chk(frame_drop, 1'b0);
    tick(8);
    chk(frame_drop, 1'b1);
    @(posedge clock) chip_select_n <= 1'b1;
    tick(8);
    chk(frame_drop, 1'b1);
    @(posedge clock) chip_select_n <= 1'b0;
    tick(8);
    chk(frame_drop, 1'b0);
    @(posedge clock) chip_select_n <= 1'b1;
    $display("timeout test done");
    i_host.wr(7'h40, 16'h0001);
    tick(4000);
    i_host.ping;
    tick(5110);
    chk({absent_host, absent_host_pin}, 2'b01);
    tick(20);
    chk({absent_host, absent_host_pin}, 2'b10);
    i_host.wr(7'h40, 16'h0005);
    i_host.ping;
    tick(3);
    chk({absent_host, absent_host_pin}, 2'b11);
    i_host.wr(7'h40, 16'h0000);
    tick(3);
    chk({absent_host, absent_host_pin}, 2'b01);
    i_host.wr(7'h40, 16'h0002);
    tick(10230);
    chk({absent_host, absent_host_pin}, 2'b01);
    tick(20);
    chk({absent_host, absent_host_pin}, 2'b10);
    i_host.wr(7'h40, 16'h0000);
    $display("watchdog test done");
    stop_test;
  end
endmodule // srm_regs_bench
